// ==== verilog/slot_timing_pkg.sv ====
// package: timing constants and carrier types for the single-wire slot engine
// assumes a 250 MHz system clock; all counts derived from microsecond figures
package slot_timing_pkg;
   // ======================================================
   // clock
   localparam int CLK_MHZ = 250;
   localparam int CNT_W   = 23;
   // ======================================================
   // regular speed times in us
   localparam int REG_WRITE_SAMPLE_US      = 30;
   localparam int REG_READ_ZERO_HOLD_US    = 30;
   localparam int REG_RESET_LOW_MIN_US     = 480;
   localparam int REG_PRESENCE_WAIT_US     = 30;
   localparam int REG_PRESENCE_LOW_US      = 120;
   // fast speed times in us
   localparam int FAST_WRITE_SAMPLE_US     = 3;
   localparam int FAST_READ_ZERO_HOLD_US   = 3;
   localparam int FAST_RESET_LOW_MIN_US    = 48;
   localparam int FAST_RESET_LOW_MAX_US    = 80;
   localparam int FAST_PRESENCE_WAIT_US    = 4;
   localparam int FAST_PRESENCE_LOW_US     = 16;
   // commit busy time in us
   localparam int COMMIT_BUSY_US           = 5000;
   // ======================================================
   // cycle counts
   localparam logic [CNT_W-1:0] REG_SAMPLE_CYC   = CNT_W'(REG_WRITE_SAMPLE_US * CLK_MHZ);
   localparam logic [CNT_W-1:0] REG_HOLD_CYC     = CNT_W'(REG_READ_ZERO_HOLD_US * CLK_MHZ);
   localparam logic [CNT_W-1:0] REG_RST_CYC      = CNT_W'(REG_RESET_LOW_MIN_US * CLK_MHZ);
   localparam logic [CNT_W-1:0] REG_PWAIT_CYC    = CNT_W'(REG_PRESENCE_WAIT_US * CLK_MHZ);
   localparam logic [CNT_W-1:0] REG_PLOW_CYC     = CNT_W'(REG_PRESENCE_LOW_US * CLK_MHZ);
   localparam logic [CNT_W-1:0] FAST_SAMPLE_CYC  = CNT_W'(FAST_WRITE_SAMPLE_US * CLK_MHZ);
   localparam logic [CNT_W-1:0] FAST_HOLD_CYC    = CNT_W'(FAST_READ_ZERO_HOLD_US * CLK_MHZ);
   localparam logic [CNT_W-1:0] FAST_RST_CYC     = CNT_W'(FAST_RESET_LOW_MIN_US * CLK_MHZ);
   localparam logic [CNT_W-1:0] FAST_RST_MAX_CYC = CNT_W'(FAST_RESET_LOW_MAX_US * CLK_MHZ);
   localparam logic [CNT_W-1:0] FAST_PWAIT_CYC   = CNT_W'(FAST_PRESENCE_WAIT_US * CLK_MHZ);
   localparam logic [CNT_W-1:0] FAST_PLOW_CYC    = CNT_W'(FAST_PRESENCE_LOW_US * CLK_MHZ);
   localparam int               COMMIT_BUSY_CYC  = COMMIT_BUSY_US * CLK_MHZ;
   // ======================================================
   // carriers
   typedef struct packed {
      logic bit_valid;
      logic bit_value;
   } rx_bit_t;
   typedef struct packed {
      logic bit_ready;
      logic bit_value;
   } tx_bit_t;
endpackage

// ==== verilog/commit_timer.sv ====
// commit busy timer: erase then write phases of a buffer commit
// assumes start is a one-cycle pulse from the slot engine's clock domain
`timescale 1ns/1ps
module commit_timer #(
   parameter int BUSY_CYC = slot_timing_pkg::COMMIT_BUSY_CYC
) (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic clk_en,
   input  wire logic start,
   output logic      busy,
   output logic      erasing,
   output logic      done
);
   localparam int HALF = BUSY_CYC / 2;
   logic [31:0] cnt_r;
   // ======================================================
   // busy window, erase in first half
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt_r   <= 32'h0;
         busy    <= 1'b0;
         erasing <= 1'b0;
         done    <= 1'b0;
      end else if (clk_en) begin
         done <= 1'b0;
         if (start && !busy) begin
            busy    <= 1'b1;
            erasing <= 1'b1;
            cnt_r   <= 32'h0;
         end else if (busy) begin
            cnt_r <= cnt_r + 32'h1;
            if (cnt_r == 32'(HALF - 1)) begin
               erasing <= 1'b0;
            end
            if (cnt_r == 32'(BUSY_CYC - 1)) begin
               busy <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end
endmodule

// ==== verilog/single_wire_slot_timing.sv ====
// single-wire slot timing engine, device side
// assumes an external pull-up on the line and a master on the same wire
`timescale 1ns/1ps
module single_wire_slot_timing #(
   parameter int COMMIT_CYC = slot_timing_pkg::COMMIT_BUSY_CYC
) (
   input  wire logic                     clk,
   input  wire logic                     reset,
   input  wire logic                     clk_en,
   input  wire logic                     line_in,
   output logic                          line_out,
   output logic                          line_oe,
   input  wire logic                     fast_req,
   input  wire logic                     read_slot,
   input  wire slot_timing_pkg::tx_bit_t tx_bit,
   output slot_timing_pkg::rx_bit_t      rx_bit,
   output logic                          tx_taken,
   output logic                          reset_seen,
   output logic                          fast_mode,
   input  wire logic                     commit_start,
   output logic                          commit_busy,
   output logic                          commit_erasing,
   output logic                          commit_done
);
   localparam int W = slot_timing_pkg::CNT_W;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_LOW,
      ST_PWAIT,
      ST_PLOW,
      ST_RZERO
   } state_t;

   state_t         state_r;
   logic           sync1_r;
   logic           sync2_r;
   logic           prev_r;
   logic [W-1:0]   cnt_r;
   logic           sampled_r;
   logic           line_low;
   logic           fall;
   logic           rise;
   logic           rst_end;

   // ======================================================
   // speed-dependent times
   function automatic logic [W-1:0] pick(input logic f, input logic [W-1:0] r,
                                         input logic [W-1:0] q);
      pick = f ? q : r;
   endfunction

   // ======================================================
   // line synchroniser and edges
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sync1_r <= 1'b1;
         sync2_r <= 1'b1;
         prev_r  <= 1'b1;
      end else if (clk_en) begin
         sync1_r <= line_in;
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
      end
   end
   assign line_low = !sync2_r;
   assign fall     = prev_r && !sync2_r;
   assign rise     = !prev_r && sync2_r;
   // end of a low long enough to be a reset pulse
   assign rst_end  = (state_r == ST_LOW) && rise && cnt_r >= pick(fast_mode,
                     slot_timing_pkg::REG_RST_CYC, slot_timing_pkg::FAST_RST_CYC);

   // ======================================================
   // slot counter, restarts on each falling edge
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt_r <= '0;
      end else if (clk_en) begin
         if (fall || rst_end) begin
            cnt_r <= '0;
         end else if (cnt_r != {W{1'b1}}) begin
            cnt_r <= cnt_r + W'(1);
         end
      end
   end

   // ======================================================
   // slot and reset/presence sequencer
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_r    <= ST_IDLE;
         sampled_r  <= 1'b0;
         reset_seen <= 1'b0;
      end else if (clk_en) begin
         reset_seen <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (fall) begin
                  state_r   <= ST_LOW;
                  sampled_r <= 1'b0;
                  if (read_slot && tx_bit.bit_ready && !tx_bit.bit_value) begin
                     state_r <= ST_RZERO;
                  end
               end
            end
            ST_LOW: begin
               if (rst_end) begin
                  // long low is a reset pulse
                  state_r <= ST_PWAIT;
               end else if (sampled_r && !line_low) begin
                  // short lows wait here for the sample point
                  state_r <= ST_IDLE;
               end else if (!sampled_r && cnt_r >= pick(fast_mode,
                         slot_timing_pkg::REG_SAMPLE_CYC,
                         slot_timing_pkg::FAST_SAMPLE_CYC)) begin
                  sampled_r <= 1'b1;
               end
            end
            ST_RZERO: begin
               if (cnt_r >= pick(fast_mode, slot_timing_pkg::REG_HOLD_CYC,
                                 slot_timing_pkg::FAST_HOLD_CYC)) begin
                  state_r <= line_low ? ST_LOW : ST_IDLE;
               end
            end
            ST_PWAIT: begin
               if (cnt_r >= pick(fast_mode, slot_timing_pkg::REG_PWAIT_CYC,
                                 slot_timing_pkg::FAST_PWAIT_CYC)) begin
                  state_r <= ST_PLOW;
               end
            end
            ST_PLOW: begin
               if (cnt_r >= pick(fast_mode, slot_timing_pkg::REG_PWAIT_CYC,
                                 slot_timing_pkg::FAST_PWAIT_CYC) +
                            pick(fast_mode, slot_timing_pkg::REG_PLOW_CYC,
                                 slot_timing_pkg::FAST_PLOW_CYC)) begin
                  state_r    <= ST_IDLE;
                  reset_seen <= 1'b1;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // ======================================================
   // speed mode
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         fast_mode <= 1'b0;
      end else if (clk_en) begin
         if (state_r == ST_LOW && rise && sampled_r &&
             cnt_r >= slot_timing_pkg::REG_RST_CYC) begin
            fast_mode <= 1'b0;
         end else if (fast_req && state_r == ST_IDLE) begin
            fast_mode <= 1'b1;
         end
      end
   end

   // ======================================================
   // received write bits, sampled at the delay point
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rx_bit   <= '0;
         tx_taken <= 1'b0;
      end else if (clk_en) begin
         rx_bit.bit_valid <= 1'b0;
         tx_taken         <= 1'b0;
         if (state_r == ST_LOW && !sampled_r && !read_slot && cnt_r == pick(fast_mode,
                slot_timing_pkg::REG_SAMPLE_CYC, slot_timing_pkg::FAST_SAMPLE_CYC)) begin
            rx_bit.bit_valid <= 1'b1;
            rx_bit.bit_value <= sync2_r;
         end
         if (state_r == ST_IDLE && fall && read_slot && tx_bit.bit_ready) begin
            tx_taken <= 1'b1;
         end
      end
   end

   // ======================================================
   // open-drain drive: only ever low
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         line_oe <= 1'b0;
      end else if (clk_en) begin
         line_oe <= (state_r == ST_PLOW) ||
                    (state_r == ST_IDLE && fall && read_slot && tx_bit.bit_ready &&
                     !tx_bit.bit_value) ||
                    (state_r == ST_RZERO && cnt_r < pick(fast_mode,
                     slot_timing_pkg::REG_HOLD_CYC, slot_timing_pkg::FAST_HOLD_CYC));
      end
   end
   assign line_out = 1'b0;

   // ======================================================
   // buffer commit timer
   commit_timer #(
      .BUSY_CYC (COMMIT_CYC)
   ) u_commit (
      .clk     (clk),
      .reset   (reset),
      .clk_en  (clk_en),
      .start   (commit_start),
      .busy    (commit_busy),
      .erasing (commit_erasing),
      .done    (commit_done)
   );
endmodule

// ==== tb/single_wire_slot_timing_monitor.sv ====
// checker: slot, presence and commit timing seen at the engine's ports
// assumes line_in is the resolved wire level and a single clock domain
`timescale 1ns/1ps
module single_wire_slot_timing_monitor #(
   parameter int COMMIT_CYC = 100
) (
   input wire logic                     clk,
   input wire logic                     reset,
   input wire logic                     clk_en,
   input wire logic                     line_in,
   input wire logic                     line_out,
   input wire logic                     line_oe,
   input wire logic                     fast_req,
   input wire logic                     read_slot,
   input wire slot_timing_pkg::tx_bit_t tx_bit,
   input wire slot_timing_pkg::rx_bit_t rx_bit,
   input wire logic                     tx_taken,
   input wire logic                     reset_seen,
   input wire logic                     fast_mode,
   input wire logic                     commit_start,
   input wire logic                     commit_busy,
   input wire logic                     commit_erasing,
   input wire logic                     commit_done
);
   // ======================================================
   // helper counters
   logic line_d_r;
   int   fall_r;
   int   high_r;
   int   oe_r;
   int   busy_r;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         line_d_r <= 1'b1;
         fall_r   <= 0;
         high_r   <= 0;
      end else begin
         line_d_r <= line_in;
         fall_r   <= (line_d_r && !line_in) ? 0 : fall_r + 1;
         high_r   <= line_in ? high_r + 1 : 0;
      end
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         oe_r   <= 0;
         busy_r <= 0;
      end else begin
         oe_r   <= line_oe ? oe_r + 1 : 0;
         busy_r <= commit_busy ? busy_r + 1 : 0;
      end
   end
   // ======================================================
   // assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   sequence rd_zero;
      $fell(line_in) && read_slot && tx_bit.bit_ready && !tx_bit.bit_value && !line_oe;
   endsequence
   sequence rd_one;
      $fell(line_in) && read_slot && tx_bit.bit_ready && tx_bit.bit_value;
   endsequence
   a_read_zero_pull: assert property (rd_zero |-> ##[1:250] line_oe)
      else $error("read zero not driven in time");
   a_read_one_idle: assert property (rd_one |-> !line_oe [*8])
      else $error("line pulled in a read one slot");
   a_write_sample: assert property (rx_bit.bit_valid |-> (fast_mode ? fall_r inside {[250:1500]}
      : fall_r inside {[3750:15000]}))
      else $error("write bit sampled outside window");
   a_pres_wait: assert property ($rose(line_oe) && !read_slot && fast_mode
      |-> high_r inside {[500:1500]} && fall_r >= 12000)
      else $error("presence wait out of range");
   a_pres_len: assert property ($fell(line_oe) && !read_slot && fast_mode
      |-> oe_r inside {[2000:6000]})
      else $error("presence length out of range");
   a_hold_len: assert property ($fell(line_oe) && read_slot
      |-> (fast_mode ? oe_r inside {[500:4000]} : oe_r inside {[3750:15000]}))
      else $error("read zero hold out of range");
   a_commit_go: assert property (commit_start && !commit_busy |-> ##[1:2] commit_busy)
      else $error("commit did not start");
   a_commit_max: assert property (busy_r <= COMMIT_CYC)
      else $error("commit busy too long");
   a_erase_inside: assert property (commit_erasing |-> commit_busy)
      else $error("erase outside commit");
endmodule
bind single_wire_slot_timing single_wire_slot_timing_monitor #(.COMMIT_CYC(COMMIT_CYC))
   single_wire_slot_timing_monitor_inst (.clk(clk), .reset(reset), .clk_en(clk_en),
   .line_in(line_in), .line_out(line_out), .line_oe(line_oe), .fast_req(fast_req),
   .read_slot(read_slot), .tx_bit(tx_bit), .rx_bit(rx_bit), .tx_taken(tx_taken),
   .reset_seen(reset_seen), .fast_mode(fast_mode), .commit_start(commit_start),
   .commit_busy(commit_busy), .commit_erasing(commit_erasing), .commit_done(commit_done));

// ==== tb/bus_master_model.sv ====
// partner: bus master driving reset pulses and slots on the shared wire
// assumes the bench resolves the wire with a pull-up
`timescale 1ns/1ps
module bus_master_model (
   input  wire logic clk,
   input  wire logic line,
   output logic      pull
);
   initial pull = 1'b0;
   // pull low, release, sample, then wait out the slot with recovery
   task automatic slot(input int low_c, input int smp_c, input int tot_c, output logic v);
      @(negedge clk);
      pull <= 1'b1;
      repeat (low_c) @(negedge clk);
      pull <= 1'b0;
      repeat (smp_c - low_c) @(negedge clk);
      v = line;
      repeat (tot_c - smp_c) @(negedge clk);
   endtask
   // measure presence wait and low time after a reset pulse
   task automatic presence(output int wt, output int lw);
      wt = 0;
      lw = 0;
      // let the released line settle high first
      while (!line) @(negedge clk);
      while (line && wt < 20000) begin
         @(negedge clk);
         wt++;
      end
      while (!line && lw < 80000) begin
         @(negedge clk);
         lw++;
      end
   endtask
endmodule

// ==== tb/tb_single_wire_slot_timing.sv ====
// testbench: master model drives the wire, bench model predicts every bit
// assumes a 250 MHz clock and a pull-up on the wire
`timescale 1ns/1ps
module tb_single_wire_slot_timing;
   localparam int US = 250;
   localparam int CC = 100;
   logic                     clk, reset, fast_req, read_slot, cstart, line, m_pull, v, got;
   logic                     l_out, l_oe, taken, seen, fast, busy, erase, done;
   slot_timing_pkg::tx_bit_t tx_bit;
   slot_timing_pkg::rx_bit_t rx_bit;
   int                       n_errors, num_checks, n_taken, n_seen, n_done, n_erase, n_rd;
   int                       busy_len, wt, lw;
   logic                     q_rx[$];
   assign line = !(m_pull || (l_oe && !l_out));
   always #2 clk = !clk;
   single_wire_slot_timing #(.COMMIT_CYC(CC)) single_wire_slot_timing_inst (.clk(clk),
      .reset(reset), .clk_en(1'b1), .line_in(line), .line_out(l_out), .line_oe(l_oe),
      .fast_req(fast_req), .read_slot(read_slot), .tx_bit(tx_bit), .rx_bit(rx_bit),
      .tx_taken(taken), .reset_seen(seen), .fast_mode(fast), .commit_start(cstart),
      .commit_busy(busy), .commit_erasing(erase), .commit_done(done));
   bus_master_model bus_master_model_inst (.clk(clk), .line(line), .pull(m_pull));
   // ======================================================
   // compare and verdict
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s: expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      if (rx_bit.bit_valid === 1'b1) chk("rx bit", q_rx.size() ? q_rx.pop_front() : 1'bx,
         rx_bit.bit_value);
      n_taken += (taken === 1'b1);
      n_seen += (seen === 1'b1);
      n_done += (done === 1'b1);
      n_erase += (erase === 1'b1);
      busy_len += (busy === 1'b1);
   end
   // ======================================================
   // slot tasks
   task automatic wr(input logic b, input int slot_us, input int low0_us);
      q_rx.push_back(b);
      bus_master_model_inst.slot(b ? US + 10 : low0_us * US, b ? US + 10 : low0_us * US,
         slot_us * US, got);
   endtask
   task automatic rd(input logic b, input int smp_c, input int slot_us);
      tx_bit = {1'b1, b};
      read_slot = 1'b1;
      n_rd++;
      bus_master_model_inst.slot(US + 10, smp_c, slot_us * US, got);
      read_slot = 1'b0;
      tx_bit = '0;
      chk("read bit", b, got);
   endtask
   // ======================================================
   // main sequence
   initial begin
      clk = 1'b0;
      reset = 1'b1;
      fast_req = 1'b0;
      read_slot = 1'b0;
      cstart = 1'b0;
      tx_bit = '0;
      {n_errors, num_checks, n_taken, n_seen, n_done, n_erase, n_rd, busy_len} = '0;
      void'($urandom(70));
      repeat (4) @(negedge clk);
      reset = 1'b0;
      chk("fast after reset", 0, fast);
      wr(1'b0, 61, 60);
      wr(1'b1, 61, 60);
      rd(1'b0, 14 * US, 61);
      fast_req = 1'b1;
      @(negedge clk);
      fast_req = 1'b0;
      repeat (3) @(negedge clk);
      chk("fast entered", 1, fast);
      // reset low also passes the write sample point: a zero
      q_rx.push_back(1'b0);
      bus_master_model_inst.slot(50 * US, 50 * US, 50 * US, got);
      bus_master_model_inst.presence(wt, lw);
      chk("presence wait", 1, wt >= 2 * US && wt <= 6 * US + 10);
      chk("presence low", 1, lw >= 8 * US && lw <= 24 * US);
      repeat (48 * US - wt - lw) @(negedge clk);
      chk("reset seen", 1, n_seen);
      chk("fast kept", 1, fast);
      for (int i = 0; i < 10; i++) begin
         v = 1'($urandom);
         if ($urandom % 2) rd(v, 480, 9);
         else wr(v, 9, 7);
      end
      repeat (20) @(negedge clk);
      chk("bits left", 0, q_rx.size());
      chk("taken count", n_rd, n_taken);
      for (int j = 0; j < 2; j++) begin
         cstart = 1'b1;
         @(negedge clk);
         cstart = 1'b0;
         repeat (5) @(negedge clk);
      end
      for (int k = 0; k < 4 * CC && busy !== 1'b0; k++) @(negedge clk);
      repeat (5) @(negedge clk);
      chk("commit done", 1, n_done);
      chk("busy bound", 1, busy_len > 0 && busy_len <= CC);
      chk("erase seen", 1, n_erase > 0);
      summarize();
   end
   initial begin
      #400000;
      n_errors++;
      summarize();
   end
endmodule
